// *** ssag_pkg.sv ***
// package: offsets, field positions and reset values of the serializer status/alias/output register slice
package ssag_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses are four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] SSAG_IDX_TARGET_ADDR = 8'h08;
  localparam logic [7:0] SSAG_IDX_ALIAS = 8'h09;
  localparam logic [7:0] SSAG_IDX_CRC_LO = 8'h0A;
  localparam logic [7:0] SSAG_IDX_CRC_HI = 8'h0B;
  localparam logic [7:0] SSAG_IDX_STATUS = 8'h0C;
  localparam logic [7:0] SSAG_IDX_PINCFG = 8'h0D;
  localparam logic [7:0] SSAG_IDX_CTRL = 8'h10;
  localparam logic [7:0] SSAG_IDX_IRQ_STAT = 8'h11;
  localparam logic [7:0] SSAG_IDX_IRQ_CLR = 8'h12;
  localparam logic [7:0] SSAG_IDX_IRQ_EN = 8'h13;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SSAG_RST_ALIAS = 8'h00;
  localparam logic [7:0] SSAG_RST_TARGET = 8'h00;
  localparam logic [15:0] SSAG_RST_CRC = 16'h0000;
  localparam logic [7:0] SSAG_RST_PINCFG = 8'h55;
  localparam logic [2:0] SSAG_REVISION = 3'h5; // arbitrary value

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SSAG_ST_LOCK = 4;
  localparam int SSAG_ST_SELFTEST = 3;
  localparam int SSAG_ST_PCLK = 2;
  localparam int SSAG_ST_LINKERR = 1;
  localparam int SSAG_ST_CABLE = 0;
  localparam int SSAG_CTRL_CRC_RESET = 0;
  // pin n uses bits 4n+3 level, 4n+2 far control, 4n drive on
  localparam int SSAG_PIN_LEVEL = 3;
  localparam int SSAG_PIN_FAR = 2;
  localparam int SSAG_PIN_DRIVE = 0;
  // interrupt events
  localparam int SSAG_IRQ_CRC = 0;
  localparam int SSAG_IRQ_LOCK_LOST = 1;
  localparam int SSAG_IRQ_CABLE_LOST = 2;
  localparam int SSAG_IRQ_W = 3;

  // remote forwarding handshake state
  typedef enum logic [1:0] {
    SSAG_FW_IDLE = 2'b00,
    SSAG_FW_SEND = 2'b01,
    SSAG_FW_DROP = 2'b10
  } ssag_fw_t;

endpackage : ssag_pkg

// *** ssag_regs.sv ***
// serializer register slice: target alias, crc count, status, output pins 0 and 1
`timescale 1ns/10ps
// Notes on behaviour
// - alias in bits 7:1; local transactions to alias get target address substituted.
// - alias zero blocks every transaction toward the remote target.
// - substitute address comes from bits 7:1 of the preceding register, sent over channel.
// - read-only 16-bit back-channel crc error count at 0x0A low, 0x0B high, reset zero.
// - status bit 4 shows receiver lock; bit 2 shows valid pixel clock.
// - status bit 3 shows crc errors seen during self-test.
// - status bit 1 set on link crc error; cleared on link loss or crc reset bit.
// - status bit 0 shows cable detected; zero for any cable fault.
// - enabled local output drives its level bit; cleared enable tri-states pin.
// - far control set makes pin an output with level from deserializer.
// - far control cleared ignores deserializer levels; local bits only.
module ssag_regs #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // local i2c address match request
  input wire logic fwd_req,
  input wire logic [6:0] fwd_addr,
  output logic fwd_ack,
  output logic fwd_hit,
  output logic fwd_valid,
  output logic [6:0] fwd_remote_addr,
  // link status inputs
  input wire logic rx_locked,
  input wire logic pclk_valid,
  input wire logic selftest_crc_fault,
  input wire logic link_crc_err,
  input wire logic cable_ok,
  // levels received from the deserializer
  input wire logic [1:0] far_level,
  // output pins 0 and 1 (oe low = driving)
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe_n,
  output logic irq
);
  import ssag_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0] target_addr_r;
  logic [7:0] remote_target_alias_r;
  logic [7:0] output_pins_0_1_config_r;
  logic [7:0] ctrl_r;
  logic [CNT_W-1:0] crc_count_r;
  logic [7:0] crc_hi_snap_r;
  logic [4:0] status_r;
  logic [SSAG_IRQ_W-1:0] irq_stat_r;
  logic [SSAG_IRQ_W-1:0] irq_en_r;
  logic prev_lock_r;
  logic prev_cable_r;
  ssag_fw_t fw_state_r;

  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [7:0] reg_idx;
  logic wr_target;
  logic wr_alias;
  logic wr_pincfg;
  logic wr_ctrl;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic rd_crc_lo;
  logic [15:0] crc_count_w;
  logic [31:0] rd_data_nxt;

  // word index from byte address; only lane 0 carries data
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
  assign rd_en = bus_req && !wb_we_i;
  assign reg_idx = {2'b00, wb_adr_i[7:2]};

  // ----------------------------------------------------------------
  // write and read strobes
  // ----------------------------------------------------------------
  // one strobe per writable register plus one for the crc low read, so each register block stays a single concern
  assign wr_target = wr_en && (reg_idx == SSAG_IDX_TARGET_ADDR);
  assign wr_alias = wr_en && (reg_idx == SSAG_IDX_ALIAS);
  assign wr_pincfg = wr_en && (reg_idx == SSAG_IDX_PINCFG);
  assign wr_ctrl = wr_en && (reg_idx == SSAG_IDX_CTRL);
  assign wr_irq_en = wr_en && (reg_idx == SSAG_IDX_IRQ_EN);
  assign wr_irq_clr = wr_en && (reg_idx == SSAG_IDX_IRQ_CLR);
  assign rd_crc_lo = rd_en && (reg_idx == SSAG_IDX_CRC_LO);

  // request taken on the edge that sees cyc and stb with ack low;
  // ack answers one cycle later and drops after one cycle, so a master
  // that keeps stb up gets one access per two cycles, never a doubled write
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // bit 0 is reserved but kept writable, as in the alias register
  always_ff @(posedge clk) begin
    if (reset) begin
      target_addr_r <= SSAG_RST_TARGET;
    end else if (wr_target) begin
      target_addr_r <= wb_dat_i[7:0];
    end
  end

  // alias lives in bits 7:1; zero there disables forwarding
  always_ff @(posedge clk) begin
    if (reset) begin
      remote_target_alias_r <= SSAG_RST_ALIAS;
    end else if (wr_alias) begin
      remote_target_alias_r <= wb_dat_i[7:0];
    end
  end

  // reset leaves both pins under far control
  always_ff @(posedge clk) begin
    if (reset) begin
      output_pins_0_1_config_r <= SSAG_RST_PINCFG;
    end else if (wr_pincfg) begin
      output_pins_0_1_config_r <= wb_dat_i[7:0];
    end
  end

  // bit 0 is a level: status bit 1 is cleared while it is set, except in a cycle with a link crc error
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= 8'h00;
    end else if (wr_ctrl) begin
      ctrl_r <= wb_dat_i[7:0];
    end
  end

  // enables gate only the irq pin, never the sticky status
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_en_r <= '0;
    end else if (wr_irq_en) begin
      irq_en_r <= wb_dat_i[SSAG_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // crc error counter and status
  // ----------------------------------------------------------------
  // saturate so a flood of errors never reads back as a small count while CNT_W is at most 16
  always_ff @(posedge clk) begin
    if (reset) begin
      crc_count_r <= CNT_W'(SSAG_RST_CRC);
    end else if (link_crc_err && (crc_count_r != '1)) begin
      crc_count_r <= crc_count_r + 1'b1;
    end
  end

  // counter seen through the 16-bit register pair; a wider build shows its low 16 bits only
  assign crc_count_w = 16'(crc_count_r);

  // high byte frozen when the low byte is read, so the pair is coherent
  always_ff @(posedge clk) begin
    if (reset) begin
      crc_hi_snap_r <= 8'h00;
    end else if (rd_crc_lo) begin
      crc_hi_snap_r <= crc_count_w[15:8];
    end
  end

  // link error bit: set wins over its clears
  always_ff @(posedge clk) begin
    if (reset) begin
      status_r <= 5'h00;
    end else begin
      status_r[SSAG_ST_LOCK] <= rx_locked;
      status_r[SSAG_ST_PCLK] <= pclk_valid;
      status_r[SSAG_ST_SELFTEST] <= selftest_crc_fault;
      status_r[SSAG_ST_CABLE] <= cable_ok;
      if (link_crc_err) begin
        status_r[SSAG_ST_LINKERR] <= 1'b1;
      end else if (!cable_ok || ctrl_r[SSAG_CTRL_CRC_RESET]) begin
        status_r[SSAG_ST_LINKERR] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [SSAG_IRQ_W-1:0] irq_events;
  logic [SSAG_IRQ_W-1:0] irq_clear;

  // loss events are falling edges; history resets low so reset makes no false event
  assign irq_events = {prev_cable_r & ~cable_ok, prev_lock_r & ~rx_locked, link_crc_err};
  assign irq_clear = wr_irq_clr ? wb_dat_i[SSAG_IRQ_W-1:0] : '0;

  // edge history for loss events
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_lock_r <= 1'b0;
      prev_cable_r <= 1'b0;
    end else begin
      prev_lock_r <= rx_locked;
      prev_cable_r <= cable_ok;
    end
  end

  // sticky: a new event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clear) | irq_events;
    end
  end

  // registered level output
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_r & ~irq_clear) | irq_events) & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // next read word; only lane 0 carries data, the upper lanes read zero
  always_comb begin
    rd_data_nxt = 32'h0000_0000;
    case (reg_idx)
      SSAG_IDX_TARGET_ADDR: rd_data_nxt = {24'h000000, target_addr_r};
      SSAG_IDX_ALIAS: rd_data_nxt = {24'h000000, remote_target_alias_r};
      SSAG_IDX_CRC_LO: rd_data_nxt = {24'h000000, crc_count_w[7:0]};
      SSAG_IDX_CRC_HI: rd_data_nxt = {24'h000000, crc_hi_snap_r};
      SSAG_IDX_STATUS: rd_data_nxt = {24'h000000, SSAG_REVISION, status_r};
      SSAG_IDX_PINCFG: rd_data_nxt = {24'h000000, output_pins_0_1_config_r};
      SSAG_IDX_CTRL: rd_data_nxt = {24'h000000, ctrl_r};
      SSAG_IDX_IRQ_STAT: rd_data_nxt = {29'h0, irq_stat_r};
      SSAG_IDX_IRQ_EN: rd_data_nxt = {29'h0, irq_en_r};
      default: rd_data_nxt = 32'h0000_0000; // unmapped and write-only reads zero
    endcase
  end

  // data held between reads so a slow master may take it late
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_o <= rd_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // alias match and address substitution
  // ----------------------------------------------------------------
  // one answer per request; the requester drops fwd_req after fwd_ack
  // a request held high after its answer is never decided twice
  always_ff @(posedge clk) begin
    if (reset) begin
      fw_state_r <= SSAG_FW_IDLE;
      fwd_ack <= 1'b0;
      fwd_hit <= 1'b0;
      fwd_valid <= 1'b0;
      fwd_remote_addr <= 7'h00;
    end else begin
      fwd_ack <= 1'b0;
      fwd_valid <= 1'b0;
      case (fw_state_r)
        SSAG_FW_IDLE: begin
          if (fwd_req) begin
            fwd_ack <= 1'b1;
            // zero alias never matches, so nothing is forwarded
            if (remote_target_alias_r[7:1] != 7'h00 && fwd_addr == remote_target_alias_r[7:1]) begin
              fwd_hit <= 1'b1;
              fwd_valid <= 1'b1;
              fwd_remote_addr <= target_addr_r[7:1];
              fw_state_r <= SSAG_FW_SEND;
            end else begin
              fwd_hit <= 1'b0;
              fw_state_r <= SSAG_FW_DROP;
            end
          end
        end
        SSAG_FW_SEND, SSAG_FW_DROP: begin
          if (!fwd_req) begin
            fw_state_r <= SSAG_FW_IDLE;
          end
        end
        default: fw_state_r <= SSAG_FW_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output pins 0 and 1
  // ----------------------------------------------------------------
  // next {oe_n, level} of one pin from its config nibble and far level
  function automatic logic [1:0] pin_drive(input logic [3:0] nib, input logic far);
    logic [1:0] res;
    if (nib[SSAG_PIN_FAR]) begin
      res = {1'b0, far};
    end else begin
      res = {~nib[SSAG_PIN_DRIVE], nib[SSAG_PIN_LEVEL]};
    end
    return res;
  endfunction : pin_drive

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      logic [1:0] pin_nxt;
      // far control overrides local bits; these pins have no direction bit
      assign pin_nxt = pin_drive(output_pins_0_1_config_r[4*g +: 4], far_level[g]);
      always_ff @(posedge clk) begin
        if (reset) begin
          pin_o[g] <= 1'b0;
          pin_oe_n[g] <= 1'b1;
        end else begin
          pin_oe_n[g] <= pin_nxt[1];
          pin_o[g] <= pin_nxt[0];
        end
      end
    end
  endgenerate

endmodule : ssag_regs

// *** ssag_regs_properties.sv ***
// checker: bus and forwarding handshake timing of the register slice
`timescale 1ns/10ps
module ssag_regs_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic fwd_req,
  input wire logic fwd_ack,
  input wire logic fwd_hit,
  input wire logic fwd_valid,
  input wire logic [6:0] fwd_remote_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // handshake steps
  // ----------------------------------------
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_fwd_answer;
    fwd_ack ##1 !fwd_ack;
  endsequence
  a_bus_answer: assert property (s_bus_req |=> wb_ack_o) else $error("bus request not acked");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  a_read_low_byte: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data not zero");
  a_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
  a_fwd_answer: assert property ($rose(fwd_req) |=> s_fwd_answer) else $error("forward not answered");
  a_valid_needs_hit: assert property (fwd_valid |-> fwd_ack && fwd_hit) else $error("valid without hit");
  a_hit_holds: assert property (!fwd_ack |-> $stable(fwd_hit)) else $error("hit moved");
  a_remote_holds: assert property (!fwd_ack |-> $stable(fwd_remote_addr)) else $error("addr moved");
endmodule : ssag_regs_checker

bind ssag_regs ssag_regs_checker i_ssag_regs_checker (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .fwd_req, .fwd_ack, .fwd_hit, .fwd_valid, .fwd_remote_addr);

// *** ssag_far_model.sv ***
// partner model: far deserializer levels and back-channel crc faults
`timescale 1ns/10ps
module ssag_far_model (
  input wire logic clk,
  output logic [1:0] far_level,
  output logic link_crc_err
);
  // quiet link until commanded
  initial begin
    far_level = 2'h0;
    link_crc_err = 1'b0;
  end
  // level change lands just after an edge
  task automatic set_level(input logic [1:0] v);
    @(posedge clk);
    far_level <= v;
  endtask : set_level
  // one-cycle pulses, gaps so each is a distinct error
  task automatic crc_burst(input int n);
    repeat (n) begin
      @(posedge clk);
      link_crc_err <= 1'b1;
      @(posedge clk);
      link_crc_err <= 1'b0;
    end
  endtask : crc_burst
endmodule : ssag_far_model

// *** ssag_regs_tb_top.sv ***
// testbench: registers, forwarding, status, interrupt and pins
`timescale 1ns/10ps
module ssag_regs_tb_top;
  import ssag_pkg::*;
  logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fwd_req, fwd_ack, fwd_hit, fwd_valid, irq;
  logic rx_locked, pclk_valid, selftest_crc_fault, cable_ok, link_crc_err;
  logic [7:0] wb_adr_i, rd;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [6:0] fwd_addr, fwd_remote_addr;
  logic [1:0] far_level, pin_o, pin_oe_n;
  int err_count = 0, compares = 0, cycles = 0;
  logic [7:0] rv_idx [4] = '{SSAG_IDX_ALIAS, SSAG_IDX_CRC_LO, SSAG_IDX_CRC_HI, SSAG_IDX_PINCFG};
  logic [7:0] rv_exp [4] = '{SSAG_RST_ALIAS, 8'h00, 8'h00, SSAG_RST_PINCFG};
  logic [3:0] st_in [5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
  logic [7:0] pc_cfg [4] = '{8'h99, 8'h88, 8'h44, 8'h11};
  logic [3:0] pc_exp [4] = '{4'hC, 4'h3, 4'h8, 4'h0};
  // 12-bit counter: saturation stays short, yet the high byte moves; pins read back their own drive
  ssag_regs #(.CNT_W(12)) i_ssag_regs (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .fwd_req, .fwd_addr, .fwd_ack, .fwd_hit, .fwd_valid, .fwd_remote_addr,
    .rx_locked, .pclk_valid, .selftest_crc_fault, .link_crc_err, .cable_ok, .far_level, .pin_i(pin_o),
    .pin_o, .pin_oe_n, .irq);
  ssag_far_model i_ssag_far_model (.clk, .far_level, .link_crc_err);
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // classic cycle: hold until ack sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rdat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx[5:0], 2'b00};
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) err_count++;
    rdat = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, rd);
    chk(nm, {8'h00, rd}, {8'h00, exp});
  endtask : rc
  // answer comes one cycle after the request is taken
  task automatic fwd(input logic [6:0] a, input logic hit, input logic [6:0] ra);
    fwd_req <= 1'b1;
    fwd_addr <= a;
    repeat (2) @(posedge clk);
    chk("fwd", {fwd_ack, fwd_hit, fwd_valid}, {1'b1, hit, hit});
    if (hit) chk("fwd_remote_addr", fwd_remote_addr, ra);
    fwd_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : fwd
  // main sequence
  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, fwd_req, rx_locked, selftest_crc_fault, pclk_valid, cable_ok} = 8'h0B;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    fwd_addr = 7'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    i_ssag_far_model.set_level(2'b01);
    repeat (2) @(posedge clk);
    chk("pins", {pin_o, pin_oe_n}, 4'h4);
    for (int i = 0; i < 4; i++) rc("reset value", rv_idx[i], rv_exp[i]);
    fwd(7'h00, 1'b0, 7'h00);
    wb(1'b1, SSAG_IDX_TARGET_ADDR, 8'h54, rd);
    fwd(7'h23, 1'b0, 7'h00);
    wb_sel_i <= 4'hE;
    wb(1'b1, SSAG_IDX_ALIAS, 8'h47, rd);
    rc("lane gate", SSAG_IDX_ALIAS, 8'h00);
    wb_sel_i <= 4'hF;
    wb(1'b1, SSAG_IDX_ALIAS, 8'h47, rd);
    fwd(7'h23, 1'b1, 7'h2A);
    fwd(7'h24, 1'b0, 7'h00);
    wb(1'b1, SSAG_IDX_CRC_LO, 8'hFF, rd);
    rc("crc low", SSAG_IDX_CRC_LO, 8'h00);
    wb(1'b1, SSAG_IDX_IRQ_EN, 8'h01, rd);
    i_ssag_far_model.crc_burst(3);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1'b1);
    rc("crc low", SSAG_IDX_CRC_LO, 8'h03);
    rc("crc high", SSAG_IDX_CRC_HI, 8'h00);
    rc("status", SSAG_IDX_STATUS, {SSAG_REVISION, 5'b10111});
    rc("irq status", SSAG_IDX_IRQ_STAT, 8'h01);
    wb(1'b1, SSAG_IDX_IRQ_CLR, 8'h01, rd);
    wb(1'b1, SSAG_IDX_IRQ_EN, 8'h00, rd);
    chk("irq", irq, 1'b0);
    wb(1'b1, SSAG_IDX_CTRL, 8'h01, rd);
    rc("status", SSAG_IDX_STATUS, {SSAG_REVISION, 5'b10101});
    wb(1'b1, SSAG_IDX_CTRL, 8'h00, rd);
    i_ssag_far_model.crc_burst(300);
    repeat (2) @(posedge clk);
    rc("crc low", SSAG_IDX_CRC_LO, 8'h2F);
    i_ssag_far_model.crc_burst(256);
    rc("crc high", SSAG_IDX_CRC_HI, 8'h01);
    i_ssag_far_model.crc_burst(4000);
    repeat (2) @(posedge clk);
    rc("crc low", SSAG_IDX_CRC_LO, 8'hFF);
    rc("crc high", SSAG_IDX_CRC_HI, 8'h0F);
    chk("irq", irq, 1'b0);
    rc("irq status", SSAG_IDX_IRQ_STAT, 8'h01);
    cable_ok <= 1'b0;
    repeat (2) @(posedge clk);
    rc("status", SSAG_IDX_STATUS, {SSAG_REVISION, 5'b10100});
    for (int i = 0; i < 5; i++) begin
      {rx_locked, selftest_crc_fault, pclk_valid, cable_ok} <= st_in[i];
      repeat (2) @(posedge clk);
      rc("status", SSAG_IDX_STATUS, {SSAG_REVISION, st_in[i][3:1], 1'b0, st_in[i][0]});
    end
    rc("irq status", SSAG_IDX_IRQ_STAT, 8'h07);
    i_ssag_far_model.set_level(2'b10);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, SSAG_IDX_PINCFG, pc_cfg[i], rd);
      repeat (2) @(posedge clk);
      chk("pins", {pin_oe_n == 2'b11 ? 2'b00 : pin_o, pin_oe_n}, pc_exp[i]);
    end
    rc("unmapped", 8'h30, 8'h00);
    end_sim();
  end
endmodule : ssag_regs_tb_top
